// [inc/reset_bor_pkg.sv]
package reset_bor_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLOCK_HZ = 10_000_000;
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int POWER_UP_TIMER_TIME_MS = 64;
  localparam int POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_TIME_MS * (CLOCK_HZ / 1000);
  localparam int BOR_FILTER_TIME_NS = 1000;
  localparam int BOR_FILTER_CYCLES =
    (BOR_FILTER_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ----------------------------------------
  // Register map (APB byte addresses)
  // ----------------------------------------
  localparam logic [11:0] BROWNOUT_CONTROL_OFFSET = 12'h000;
  localparam logic [11:0] RESET_CAUSE_OFFSET = 12'h004;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int SW_BROWNOUT_ENABLE_BIT = 7;
  localparam int BROWNOUT_READY_BIT = 0;
  localparam logic SW_BROWNOUT_ENABLE_RESET = 1'b1;
  localparam logic [7:0] RESET_CAUSE_RESET = 8'h01;

  // Reset cause bit positions
  localparam int CAUSE_POWER_ON = 0;
  localparam int CAUSE_BROWN_OUT = 1;
  localparam int CAUSE_MASTER_CLEAR = 2;
  localparam int CAUSE_WATCHDOG = 3;
  localparam int CAUSE_INSTRUCTION = 4;
  localparam int CAUSE_STACK_OVERFLOW = 5;
  localparam int CAUSE_STACK_UNDERFLOW = 6;
  localparam int CAUSE_PROG_EXIT = 7;

  // ----------------------------------------
  // Brown-out mode encodings
  // ----------------------------------------
  localparam logic [1:0] BOR_MODE_ALWAYS_ON = 2'h3;
  localparam logic [1:0] BOR_MODE_SLEEP_OFF = 2'h2;
  localparam logic [1:0] BOR_MODE_SOFTWARE = 2'h1;
  localparam logic [1:0] BOR_MODE_OFF = 2'h0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] brownout_mode_select;
    logic brownout_level_select;
    logic powerup_timer_enable_n;
    logic master_clear_enable;
    logic stack_reset_enable;
  } config_word_t;

  typedef struct packed {
    logic watchdog_timer;
    logic reset_instruction;
    logic stack_overflow;
    logic stack_underflow;
    logic prog_mode_exit;
  } reset_events_t;

endpackage

// [rtl/reset_and_brownout_control.sv]
// The address map and the APB interface to the registers were chosen for this implementation.
module reset_and_brownout_control #(
  parameter int POWER_UP_TIMER_CYCLES = reset_bor_pkg::POWER_UP_TIMER_CYCLES,
  parameter int FILTER_CYCLES = reset_bor_pkg::BOR_FILTER_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire reset_bor_pkg::config_word_t i_config,
  input wire reset_bor_pkg::reset_events_t i_events,
  input wire logic i_supply_low,
  input wire logic i_bor_analog_ready,
  input wire logic i_master_clear_input_n,
  input wire logic i_sleep,
  input wire logic i_osc_start_done,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_core_reset,
  output logic o_bor_circuit_enable,
  output logic o_brownout_level_select,
  output logic o_wake_hold
);

  // ----------------------------------------
  // Types and functions
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_POWER_UP_TIMER,
    ST_OSC,
    ST_RUN
  } seq_state_t;

  localparam int POWER_UP_TIMER_W = $clog2(POWER_UP_TIMER_CYCLES + 1);
  localparam int FILT_W = $clog2(FILTER_CYCLES + 1);

  // Counter widths follow the parameters
  // Timer count saturates at its end value
  // Filter count saturates at its end value
  // Both clear whenever their condition drops

  // Brown-out circuit powered for this mode and sleep state
  function automatic logic bor_enabled(input logic [1:0] mode, input logic sleep,
                                       input logic sw_en);
    case (mode)
      reset_bor_pkg::BOR_MODE_ALWAYS_ON: bor_enabled = 1'b1;
      reset_bor_pkg::BOR_MODE_SLEEP_OFF: bor_enabled = !sleep;
      reset_bor_pkg::BOR_MODE_SOFTWARE: bor_enabled = sw_en;
      default: bor_enabled = 1'b0;
    endcase
  endfunction

  // Start-up waits for ready and good supply only in forced-on modes
  function automatic logic startup_waits(input logic [1:0] mode);
    startup_waits = (mode == reset_bor_pkg::BOR_MODE_ALWAYS_ON) ||
                    (mode == reset_bor_pkg::BOR_MODE_SLEEP_OFF);
  endfunction

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;

  // Two stages for supply, analog ready and master clear pin
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= 3'h4;
      sync2_reg <= 3'h4;
    end else if (i_clk_en) begin
      sync1_reg <= {i_master_clear_input_n, i_bor_analog_ready, i_supply_low};
      sync2_reg <= sync1_reg;
    end
  end

  // Only the second stage feeds logic
  // Master clear stage resets high: pin idle
  // Ready and supply stages reset low
  // Clock enable low freezes both stages
  wire supply_low_s = sync2_reg[0];
  wire analog_ready_s = sync2_reg[1];
  wire master_clear_n_s = sync2_reg[2];

  // ----------------------------------------
  // Brown-out detection
  // ----------------------------------------
  logic sw_en_reg;
  logic sw_en_next;
  logic [FILT_W-1:0] filt_cnt_reg;
  logic [FILT_W-1:0] filt_cnt_next;
  logic bor_trip_reg;
  logic bor_trip_next;
  logic [1:0] bor_mode;

  assign bor_mode = i_config.brownout_mode_select;
  wire circuit_on = bor_enabled(bor_mode, i_sleep, sw_en_reg);
  wire circuit_ready = o_bor_circuit_enable && analog_ready_s;
  wire protect = circuit_on && circuit_ready;
  wire low_seen = protect && supply_low_s;
  wire filt_done = (filt_cnt_reg == FILT_W'(FILTER_CYCLES));

  // Low supply counted only while protecting
  // Circuit off or not ready: no trip possible
  // Any good sample restarts the filter
  // Filter counter: short dips never reach the trip
  assign filt_cnt_next = !low_seen ? '0 :
                         filt_done ? filt_cnt_reg : filt_cnt_reg + FILT_W'(1);
  // Trip holds until supply recovers
  assign bor_trip_next = low_seen && (filt_done || bor_trip_reg);

  // Brown-out filter and trip
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      filt_cnt_reg <= '0;
      bor_trip_reg <= 1'b0;
    end else if (i_clk_en) begin
      filt_cnt_reg <= filt_cnt_next;
      bor_trip_reg <= bor_trip_next;
    end
  end

  // Enable follows mode, sleep and software bit
  // Level select is a plain registered copy
  // Wake hold only in sleep-off mode
  // Analog enable, level select and wake hold
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bor_circuit_enable <= 1'b0;
      o_brownout_level_select <= 1'b0;
      o_wake_hold <= 1'b0;
    end else if (i_clk_en) begin
      o_bor_circuit_enable <= circuit_on;
      o_brownout_level_select <= i_config.brownout_level_select;
      o_wake_hold <= (bor_mode == reset_bor_pkg::BOR_MODE_SLEEP_OFF) &&
                     !circuit_ready;
    end
  end

  // ----------------------------------------
  // Start-up sequencer
  // ----------------------------------------
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [POWER_UP_TIMER_W-1:0] power_up_timer_cnt_reg;
  logic [POWER_UP_TIMER_W-1:0] power_up_timer_cnt_next;

  // Sequence: hold, timer, oscillator, run
  // Hold waits for trip release and supply
  // Timer skipped when its enable bit is one
  // Oscillator wait follows the timer
  // Run stays until a power-style event
  // Power-on style events restart the whole sequence
  wire power_event = bor_trip_reg || i_events.prog_mode_exit;
  // Forced-on modes need a ready circuit and good supply first
  wire supply_ok = !startup_waits(bor_mode) ||
                   (circuit_ready && !supply_low_s);
  wire hold_released = !bor_trip_reg && supply_ok;
  wire power_up_timer_done = i_config.powerup_timer_enable_n ||
                   (power_up_timer_cnt_reg == POWER_UP_TIMER_W'(POWER_UP_TIMER_CYCLES));

  // Next state of the sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_HOLD: begin
        if (hold_released) begin
          state_next = ST_POWER_UP_TIMER;
        end
      end
      ST_POWER_UP_TIMER: begin
        if (power_up_timer_done) begin
          state_next = ST_OSC;
        end
      end
      ST_OSC: begin
        if (i_osc_start_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: state_next = ST_RUN;
      default: state_next = ST_HOLD;
    endcase
    if (power_event) begin
      state_next = ST_HOLD;
    end
  end

  // Timer runs independent of master clear
  // Master clear held long: run starts at release
  // Timer counts only in its own state
  assign power_up_timer_cnt_next = (state_reg != ST_POWER_UP_TIMER) ? '0 :
                         power_up_timer_done ? power_up_timer_cnt_reg : power_up_timer_cnt_reg + POWER_UP_TIMER_W'(1);

  // Sequencer state and power-up timer
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_HOLD;
      power_up_timer_cnt_reg <= '0;
    end else if (i_clk_en) begin
      state_reg <= state_next;
      power_up_timer_cnt_reg <= power_up_timer_cnt_next;
    end
  end

  // ----------------------------------------
  // Core reset
  // ----------------------------------------
  wire master_clear_hold = i_config.master_clear_enable && !master_clear_n_s;
  wire stack_event = i_config.stack_reset_enable &&
                     (i_events.stack_overflow || i_events.stack_underflow);
  wire pulse_event = i_events.watchdog_timer || i_events.reset_instruction ||
                     stack_event;
  wire core_reset_next = (state_reg != ST_RUN) || power_event ||
                         master_clear_hold || pulse_event;

  // Pulse events give one cycle of reset
  // Stack events gated by their config bit
  // Master clear gated by its enable bit
  // Sequencer holds reset until run state
  // Registered so release lines up with the clock
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_reset <= 1'b1;
    end else if (i_clk_en) begin
      o_core_reset <= core_reset_next;
    end
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // Zero wait states: answer in first access cycle
  // Writes land only with pready high
  // Unmapped addresses answer with slave error
  // Upper data bits read as zero
  wire setup_phase = i_psel && !i_penable;
  wire access_write = i_psel && i_penable && o_pready && i_pwrite;
  wire hit_control = (i_paddr == reset_bor_pkg::BROWNOUT_CONTROL_OFFSET);
  wire hit_cause = (i_paddr == reset_bor_pkg::RESET_CAUSE_OFFSET);
  wire wr_control = access_write && hit_control;
  wire wr_cause = access_write && hit_cause;

  logic [7:0] cause_reg;
  logic [7:0] cause_next;
  logic [7:0] cause_set;
  logic [7:0] control_view;
  logic [31:0] read_mux;

  // Control view: enable at bit 7, ready at bit 0, rest zero
  always_comb begin
    control_view = 8'h00;
    control_view[reset_bor_pkg::SW_BROWNOUT_ENABLE_BIT] = sw_en_reg;
    control_view[reset_bor_pkg::BROWNOUT_READY_BIT] = circuit_ready;
  end

  assign read_mux = hit_control ? {24'h000000, control_view} :
                    hit_cause ? {24'h000000, cause_reg} : 32'h00000000;

  // Power-style event wins over a write
  // Bit stays writable in every mode
  // Software enable: written by software, set again by brown-out or program-mode exit
  assign sw_en_next = power_event ? reset_bor_pkg::SW_BROWNOUT_ENABLE_RESET :
                      wr_control ? i_pwdata[reset_bor_pkg::SW_BROWNOUT_ENABLE_BIT] :
                      sw_en_reg;

  // Power-on bit set only by async reset
  // Other bits set by their own event
  // Cause events, each sticky
  always_comb begin
    cause_set = 8'h00;
    cause_set[reset_bor_pkg::CAUSE_BROWN_OUT] = bor_trip_reg;
    cause_set[reset_bor_pkg::CAUSE_MASTER_CLEAR] = master_clear_hold;
    cause_set[reset_bor_pkg::CAUSE_WATCHDOG] = i_events.watchdog_timer;
    cause_set[reset_bor_pkg::CAUSE_INSTRUCTION] = i_events.reset_instruction;
    cause_set[reset_bor_pkg::CAUSE_STACK_OVERFLOW] =
      i_config.stack_reset_enable && i_events.stack_overflow;
    cause_set[reset_bor_pkg::CAUSE_STACK_UNDERFLOW] =
      i_config.stack_reset_enable && i_events.stack_underflow;
    cause_set[reset_bor_pkg::CAUSE_PROG_EXIT] = i_events.prog_mode_exit;
  end

  // Write one to clear; a new event wins over the clear
  assign cause_next = (cause_reg & ~(wr_cause ? i_pwdata[7:0] : 8'h00)) | cause_set;

  // Async reset acts as power-on reset
  // Enable bit and cause word reset here
  // Register file
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_en_reg <= reset_bor_pkg::SW_BROWNOUT_ENABLE_RESET;
      cause_reg <= reset_bor_pkg::RESET_CAUSE_RESET;
    end else if (i_clk_en) begin
      sw_en_reg <= sw_en_next;
      cause_reg <= cause_next;
    end
  end

  // Read data zero outside a read answer
  // Error flag stands only with pready
  // Back-to-back transfers need no idle cycle
  // APB answer: registered in setup, valid in first access cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end else if (i_clk_en) begin
      o_pready <= setup_phase;
      o_pslverr <= setup_phase && !(hit_control || hit_cause);
      o_prdata <= (setup_phase && !i_pwrite) ? read_mux : 32'h00000000;
    end
  end

endmodule

// [tb/reset_bor_asserts.sv]
module reset_bor_asserts #(
  parameter int POWER_UP_TIMER_CYCLES = 20,
  parameter int FILTER_CYCLES = 3
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire reset_bor_pkg::config_word_t i_config,
  input wire reset_bor_pkg::reset_events_t i_events,
  input wire logic i_master_clear_input_n,
  input wire logic i_sleep,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_core_reset,
  input wire logic o_bor_circuit_enable,
  input wire logic o_brownout_level_select,
  input wire logic o_wake_hold
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wire logic ctrl_rd = o_pready && !i_pwrite && (i_paddr == 12'h000);
  wire logic [1:0] mode = i_config.brownout_mode_select;

  setup_answer_a: assert property ((i_psel && !i_penable && i_clk_en) |=> o_pready)
    else $error("no answer after setup");
  pready_once_a: assert property (o_pready |=> !o_pready)
    else $error("pready held too long");
  idle_data_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside answer");
  ctrl_zero_a: assert property (ctrl_rd |-> o_prdata[31:8] == 24'h0 && o_prdata[6:1] == 6'h00)
    else $error("unused control bits set");
  ready_power_a: assert property ((ctrl_rd && o_prdata[0]) |-> o_bor_circuit_enable)
    else $error("ready while circuit off");
  event_reset_a: assert property ((i_clk_en && |i_events[4:3]) |=> o_core_reset)
    else $error("event gave no reset");
  level_copy_a: assert property (($past(i_rst_n) && $past(i_clk_en))
    |-> o_brownout_level_select == $past(i_config.brownout_level_select))
    else $error("trip level not copied");
  mode_off_a: assert property (($past(i_rst_n) && mode == reset_bor_pkg::BOR_MODE_OFF)
    |=> !o_bor_circuit_enable)
    else $error("circuit on in off mode");
  always_on_a: assert property (($past(i_rst_n) && mode == reset_bor_pkg::BOR_MODE_ALWAYS_ON)
    |=> o_bor_circuit_enable)
    else $error("circuit off in always-on mode");
  sleep_off_a: assert property (($past(i_rst_n) && mode == reset_bor_pkg::BOR_MODE_SLEEP_OFF
    && i_sleep) |-> ##[1:2] !o_bor_circuit_enable)
    else $error("circuit on during sleep");
  master_clear_input_hold_a: assert property ((i_config.master_clear_enable && !i_master_clear_input_n)[*4]
    |=> o_core_reset)
    else $error("master clear not held");
  wake_hold_a: assert property (($past(i_rst_n) && mode != reset_bor_pkg::BOR_MODE_SLEEP_OFF)
    |=> !o_wake_hold)
    else $error("wake delayed outside sleep-off");
endmodule

bind reset_and_brownout_control reset_bor_asserts #(
  .POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES),
  .FILTER_CYCLES(FILTER_CYCLES)
) u_chk (
  .i_clock, .i_rst_n, .i_clk_en, .i_config, .i_events, .i_master_clear_input_n, .i_sleep,
  .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_prdata,
  .o_pready, .o_core_reset, .o_bor_circuit_enable, .o_brownout_level_select, .o_wake_hold
);

// [tb/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PW = 20;
  logic clk, rst_n, slow, ardy, master_clear_input_n, slp, psel, pen, pwr, rdy, err, crst, ben, lvl, whold;
  logic re, ce, osc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  reset_bor_pkg::config_word_t cfg;
  reset_bor_pkg::reset_events_t ev;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;

  reset_and_brownout_control #(.POWER_UP_TIMER_CYCLES(PW), .FILTER_CYCLES(3)) u_dut (
    .i_clock(clk), .i_rst_n(rst_n), .i_clk_en(ce), .i_config(cfg), .i_events(ev),
    .i_supply_low(slow), .i_bor_analog_ready(ardy), .i_master_clear_input_n(master_clear_input_n),
    .i_sleep(slp), .i_osc_start_done(osc), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(rdy), .o_pslverr(err), .o_core_reset(crst), .o_bor_circuit_enable(ben),
    .o_brownout_level_select(lvl), .o_wake_hold(whold));

  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("mismatches %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %0h got %0h", nm, exp, got);
    end
  endtask

  // APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prdata;
    re = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  task automatic boot(input logic [1:0] m, input logic tn);
    rst_n <= 1'b0;
    cfg.brownout_mode_select <= m;
    cfg.powerup_timer_enable_n <= tn;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic rel(output int c);
    c = 0;
    while (crst !== 1'b0 && c < 300) begin
      @(posedge clk);
      c++;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    cfg = 6'h3B;
    ev = 5'h00;
    {slow, slp, psel, pen, pwr, rst_n} = 6'h00;
    {ardy, master_clear_input_n, ce, osc} = 4'hF;
    paddr = 12'h000;
    pwdata = 32'h0;
    boot(2'h3, 1'b0);
    rel(n);
    chk("power_up_timer_min", n >= PW, 1'b1);
    chk("power_up_timer_max", n <= PW + 12, 1'b1);
    chk("ben", ben, 1'b1);
    chk("lvl", lvl, 1'b1);
    rchk("ctrl", 12'h000, 32'h81);
    rchk("cause", 12'h004, 32'h01);
    apb(1'b1, 12'h008, 32'h0);
    chk("slverr", re, 1'b1);
    rchk("bad_rd", 12'h008, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    rchk("sw_inert", 12'h000, 32'h01);
    chk("ben_kept", ben, 1'b1);
    apb(1'b1, 12'h004, 32'hFF);
    for (int i = 4; i >= 0; i--) begin
      ev <= 5'h01 << i;
      @(posedge clk);
      ev <= 5'h00;
      @(posedge clk);
      chk("ev_rst", crst, 1'b1);
      rel(n);
      apb(1'b0, 12'h004, 32'h0);
      chk("ev_cause", rd[7 - i], 1'b1);
      rchk("ev_sw", 12'h000, {i == 0, 7'h01});
      apb(1'b1, 12'h004, 32'hFF);
    end
    apb(1'b1, 12'h000, 32'h0);
    slow <= 1'b1;
    @(posedge clk);
    slow <= 1'b0;
    repeat (10) @(posedge clk);
    chk("glitch", crst, 1'b0);
    slow <= 1'b1;
    repeat (10) @(posedge clk);
    chk("bor", crst, 1'b1);
    slow <= 1'b0;
    rel(n);
    chk("bor_tmr", n >= PW, 1'b1);
    rchk("bor_cause", 12'h004, 32'h02);
    rchk("bor_sw", 12'h000, 32'h81);
    master_clear_input_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk("master_clear_input", crst, 1'b1);
    master_clear_input_n <= 1'b1;
    rel(n);
    chk("master_clear_input_rel", n < PW, 1'b1);
    osc <= 1'b0;
    boot(2'h3, 1'b1);
    repeat (30) @(posedge clk);
    chk("osc_wait", crst, 1'b1);
    osc <= 1'b1;
    rel(n);
    chk("bypass", n < PW, 1'b1);
    ardy <= 1'b0;
    boot(2'h3, 1'b1);
    repeat (40) @(posedge clk);
    chk("wait_rdy", crst, 1'b1);
    ardy <= 1'b1;
    rel(n);
    chk("rdy_rel", n < 12, 1'b1);
    ardy <= 1'b0;
    boot(2'h1, 1'b1);
    rel(n);
    chk("sw_start", n < 12, 1'b1);
    chk("sw_on", ben, 1'b1);
    rchk("sw_rdy", 12'h000, 32'h80);
    apb(1'b1, 12'h000, 32'h0);
    ardy <= 1'b1;
    slow <= 1'b1;
    repeat (12) @(posedge clk);
    chk("sw_off", ben, 1'b0);
    chk("sw_nobor", crst, 1'b0);
    slow <= 1'b0;
    boot(2'h2, 1'b1);
    rel(n);
    slp <= 1'b1;
    repeat (4) @(posedge clk);
    chk("slp_off", ben, 1'b0);
    chk("slp_hold", whold, 1'b1);
    slp <= 1'b0;
    repeat (8) @(posedge clk);
    chk("wake", whold, 1'b0);
    boot(2'h0, 1'b1);
    rel(n);
    chk("off", ben, 1'b0);
    slow <= 1'b1;
    repeat (12) @(posedge clk);
    chk("off_nobor", crst, 1'b0);
    slow <= 1'b0;
    ce <= 1'b0;
    ev <= 5'h10;
    @(posedge clk);
    ev <= 5'h00;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    chk("frozen", crst, 1'b0);
    rchk("frozen_cause", 12'h004, 32'h01);
    report_and_stop();
  end
endmodule
